/* logic/uap_map.svh */
/*
 * Register offsets, field positions, reset values and timing figures of the
 * auxiliary pin block. Assumes inclusion by bare name from package and RTL.
 */
`ifndef UAP_MAP_SVH
`define UAP_MAP_SVH

// ====================================================================
// Register byte offsets
`define UAP_REG_PIN_SEL 4'h0
`define UAP_REG_CTRL 4'h4
`define UAP_REG_BAUD 4'h8
`define UAP_REG_STATUS 4'hc

// ====================================================================
// Fields
`define UAP_SEL_W 3
`define UAP_SEL_STRIDE 4
`define UAP_CTRL_PD_BIT 0
`define UAP_ST_SUSP_BIT 0
`define UAP_ST_STROBE_BIT 1
`define UAP_ST_TXACT_BIT 2
`define UAP_ST_RXACT_BIT 3
`define UAP_ST_RI_BIT 4

// ====================================================================
// Pin function codes
`define UAP_FN_LINE_EN 3'h0
`define UAP_FN_PWR_EN 3'h1
`define UAP_FN_SLEEP 3'h2
`define UAP_FN_TX_LED 3'h3
`define UAP_FN_RX_LED 3'h4
`define UAP_FN_TXRX_LED 3'h5
`define UAP_FN_CLKOUT 3'h6
`define UAP_FN_OFF 3'h7

// ====================================================================
// Reset values
`define UAP_RST_SEL0 `UAP_FN_TX_LED
`define UAP_RST_SEL1 `UAP_FN_RX_LED
`define UAP_RST_SEL2 `UAP_FN_LINE_EN
`define UAP_RST_SEL3 `UAP_FN_PWR_EN
`define UAP_RST_PD 1'b0
`define UAP_RST_BAUD 16'h015b

// ====================================================================
// Timing
`define UAP_CLK_HZ 40000000
`define UAP_MAX_BAUD 3000000
`define UAP_AUX_CLK_HZ 12000000
`define UAP_LED_STRETCH_MS 50
`define UAP_LED_STRETCH_CYC (`UAP_CLK_HZ / 1000 * `UAP_LED_STRETCH_MS)
`define UAP_MIN_BIT_CYC ((`UAP_CLK_HZ + `UAP_MAX_BAUD - 1) / `UAP_MAX_BAUD)

`endif

/* logic/uap_oneshot.sv */
/*
 * Retriggerable one-shot that stretches activity pulses for an LED.
 * Assumes trig is a one-cycle pulse on core_clk.
 */
module uap_oneshot #(
	parameter int CYCLES = 2000000
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Activity
	input wire logic trig,
	output logic active_r
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);

	logic [CW-1:0] cnt_r;

	// ====================================================================
	// Stretch counter, restarted by every byte
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (trig) begin
			cnt_r <= LOAD;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - CW'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			active_r <= 1'b0;
		end else begin
			active_r <= trig || (cnt_r > CW'(1));
		end
	end

	// ====================================================================
	// Checks
	chk_shot_retrig: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig |=> active_r [*2]) else $error("one-shot did not stretch");

	chk_shot_ends: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cnt_r == '0) && !trig |=> !active_r) else $error("one-shot stuck");

endmodule

/* logic/uap_pkg.sv */
/*
 * Types of the auxiliary pin block.
 * Assumes uap_map.svh is on the include path.
 */
`include "uap_map.svh"

package uap_pkg;

	// ====================================================================
	// Pin functions
	typedef enum logic [2:0] {
		UAP_FN_LINE_EN = `UAP_FN_LINE_EN,
		UAP_FN_PWR_EN = `UAP_FN_PWR_EN,
		UAP_FN_SLEEP = `UAP_FN_SLEEP,
		UAP_FN_TX_LED = `UAP_FN_TX_LED,
		UAP_FN_RX_LED = `UAP_FN_RX_LED,
		UAP_FN_TXRX_LED = `UAP_FN_TXRX_LED,
		UAP_FN_CLKOUT = `UAP_FN_CLKOUT,
		UAP_FN_OFF = `UAP_FN_OFF
	} uap_fn_t;

	// ====================================================================
	// Transmit-enable sequencer
	typedef enum logic [2:0] {
		UAP_ST_IDLE = 3'b001,
		UAP_ST_LEAD = 3'b010,
		UAP_ST_SEND = 3'b100
	} uap_state_t;

endpackage

/* logic/uap_top.sv */
/*
 * Auxiliary pin functions of a USB serial bridge: transmit-enable strobe,
 * suspend indicators, stretched activity LEDs, gated clock output, ring
 * wakeup and handshake lines, with an Avalon-MM register slave.
 * Assumes the serial transmitter, USB engine and bus are on core_clk (40 MHz).
 */
// Function
// - Strobe rises one full bit period before the first character's start bit; later characters of a burst start at the stop bit.
// - Strobe falls at the last character's stop bit; not configurable.
// - Strobe is on only while characters are being sent and for the lead bit before the first one.
// - Default: pin two carries strobe, pin three carries power-enable.
// - Power-enable (active low) is deasserted during suspend.
// - Sleep indicator is low in suspend, high when active.
// - Clock-output pin drives 12 MHz, stopped in suspend.
// - Ring input falling low during suspend raises a one-cycle remote wakeup request.
// - Serial data on TXD/RXD; RTS and CTS give hardware flow control.
// - Any pin may be a transmit, receive or combined activity LED.
// - LED pins float when idle and drive low during activity.
// - Each LED indication is stretched by a digital one-shot.
// - Serial bit rate never exceeds 3 Mbaud.
// - Power-enable high in suspend; optional pull-down of serial lines then.
`include "uap_map.svh"

module uap_top #(
	parameter int LED_STRETCH = `UAP_LED_STRETCH_CYC,
	parameter int PINS = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// USB engine
	input wire logic usb_suspend,
	output logic remote_wakeup,
	// Serial transmitter and receiver
	input wire logic tx_pending,
	input wire logic tx_stop_bit,
	input wire logic tx_serial,
	input wire logic rx_byte_done,
	input wire logic rx_room,
	output logic tx_start,
	output logic [15:0] baud_div,
	output logic rxd_sync,
	output logic cts_ok,
	// Serial pins
	output logic txd_pin,
	input wire logic rxd_pin,
	output logic rts_n_pin,
	input wire logic cts_n_pin,
	input wire logic ri_n_pin,
	// Auxiliary pins
	output logic [PINS-1:0] aux_out,
	output logic [PINS-1:0] aux_oe
);

	localparam logic [15:0] MIN_BIT = 16'(`UAP_MIN_BIT_CYC);
	localparam int CLK_MHZ = `UAP_CLK_HZ / 1000000;
	localparam int STEP_I = 2 * `UAP_AUX_CLK_HZ / 1000000;
	localparam logic [6:0] PH_MOD = 7'(CLK_MHZ);
	localparam logic [6:0] PH_STEP = 7'(STEP_I);
	localparam logic [`UAP_SEL_W-1:0] SEL_RST [4] = '{`UAP_RST_SEL0, `UAP_RST_SEL1,
		`UAP_RST_SEL2, `UAP_RST_SEL3};

	logic wait_r;
	logic [31:0] rdata_r;
	uap_pkg::uap_fn_t sel_r [PINS];
	logic pd_r;
	logic [15:0] baud_r;
	logic [15:0] baud_eff_r;
	uap_pkg::uap_state_t state_r;
	uap_pkg::uap_state_t state_nxt;
	logic [15:0] lead_cnt_r;
	logic [15:0] lead_len_r;
	logic strobe_r;
	logic tx_start_r;
	logic [1:0] rxd_s_r;
	logic [1:0] cts_s_r;
	logic cts_ok_r;
	logic [2:0] ri_s_r;
	logic wake_r;
	logic txd_r;
	logic rts_n_r;
	logic [6:0] ph_r;
	logic [6:0] ph_sum;
	logic clk_r;
	logic [1:0] act;
	logic [1:0] trig;
	logic [PINS-1:0] out_r;
	logic [PINS-1:0] oe_r;
	logic accept;
	logic go_ok;

	// ====================================================================
	// Bus slave: one wait cycle, then a one-cycle answer
	assign accept = (avs_read || avs_write) && !wait_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= !((avs_read || avs_write) && wait_r);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= '0;
		end else if (avs_read && wait_r) begin
			rdata_r <= '0;
			case (avs_address)
				`UAP_REG_PIN_SEL: begin
					for (int i = 0; i < PINS; i++) begin
						rdata_r[i*`UAP_SEL_STRIDE +: `UAP_SEL_W] <= sel_r[i];
					end
				end
				`UAP_REG_CTRL: rdata_r[`UAP_CTRL_PD_BIT] <= pd_r;
				`UAP_REG_BAUD: rdata_r[15:0] <= baud_r;
				`UAP_REG_STATUS: begin
					rdata_r[`UAP_ST_SUSP_BIT] <= usb_suspend;
					rdata_r[`UAP_ST_STROBE_BIT] <= strobe_r;
					rdata_r[`UAP_ST_TXACT_BIT] <= act[0];
					rdata_r[`UAP_ST_RXACT_BIT] <= act[1];
					rdata_r[`UAP_ST_RI_BIT] <= !ri_s_r[1];
				end
				default: rdata_r <= '0;
			endcase
		end
	end

	// Selection fields start from the factory map; software may override
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < PINS; i++) begin
				sel_r[i] <= uap_pkg::uap_fn_t'(SEL_RST[i % 4]);
			end
		end else if (accept && avs_write && avs_address == `UAP_REG_PIN_SEL) begin
			for (int i = 0; i < PINS; i++) begin
				if (avs_byteenable[(i*`UAP_SEL_STRIDE)/8]) begin
					sel_r[i] <= uap_pkg::uap_fn_t'(
						avs_writedata[i*`UAP_SEL_STRIDE +: `UAP_SEL_W]);
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_r <= `UAP_RST_PD;
		end else if (accept && avs_write && avs_address == `UAP_REG_CTRL && avs_byteenable[0]) begin
			pd_r <= avs_writedata[`UAP_CTRL_PD_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_r <= `UAP_RST_BAUD;
		end else if (accept && avs_write && avs_address == `UAP_REG_BAUD) begin
			if (avs_byteenable[0]) begin
				baud_r[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				baud_r[15:8] <= avs_writedata[15:8];
			end
		end
	end

	// Too short a divisor is raised to the 3 Mbaud floor
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_eff_r <= `UAP_RST_BAUD;
		end else begin
			baud_eff_r <= (baud_r < MIN_BIT) ? MIN_BIT : baud_r;
		end
	end

	// ====================================================================
	// Pin synchronisers; first stages feed only second stages
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_s_r <= 2'h3;
			cts_s_r <= 2'h3;
			ri_s_r <= 3'h7;
			cts_ok_r <= 1'b0;
		end else begin
			rxd_s_r <= {rxd_s_r[0], rxd_pin};
			cts_s_r <= {cts_s_r[0], cts_n_pin};
			ri_s_r <= {ri_s_r[1:0], ri_n_pin};
			cts_ok_r <= !cts_s_r[1];
		end
	end

	// ====================================================================
	// Transmit-enable sequencer
	assign go_ok = tx_pending && !cts_s_r[1] && !usb_suspend;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			uap_pkg::UAP_ST_IDLE: begin
				if (go_ok) begin
					state_nxt = uap_pkg::UAP_ST_LEAD;
				end
			end
			uap_pkg::UAP_ST_LEAD: begin
				if (lead_cnt_r == 16'h0000) begin
					state_nxt = uap_pkg::UAP_ST_SEND;
				end
			end
			uap_pkg::UAP_ST_SEND: begin
				if (tx_stop_bit && !go_ok) begin
					state_nxt = uap_pkg::UAP_ST_IDLE;
				end
			end
			default: state_nxt = uap_pkg::UAP_ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= uap_pkg::UAP_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Lead count is latched at entry so a divisor write cannot shorten it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lead_cnt_r <= '0;
			lead_len_r <= '0;
		end else if (state_r == uap_pkg::UAP_ST_IDLE) begin
			lead_cnt_r <= baud_eff_r;
			lead_len_r <= baud_eff_r;
		end else if (lead_cnt_r != 16'h0000) begin
			lead_cnt_r <= lead_cnt_r - 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_r <= 1'b0;
			tx_start_r <= 1'b0;
		end else begin
			strobe_r <= state_nxt != uap_pkg::UAP_ST_IDLE;
			tx_start_r <= (state_r == uap_pkg::UAP_ST_LEAD && lead_cnt_r == 16'h0000)
				|| (state_r == uap_pkg::UAP_ST_SEND && tx_stop_bit && go_ok);
		end
	end

	// ====================================================================
	// Serial lines, flow control, wakeup
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txd_r <= 1'b1;
			rts_n_r <= 1'b1;
			wake_r <= 1'b0;
		end else begin
			txd_r <= (usb_suspend && pd_r) ? 1'b0 : tx_serial;
			rts_n_r <= (usb_suspend && pd_r) ? 1'b0 : !rx_room;
			wake_r <= usb_suspend && !ri_s_r[1] && ri_s_r[2];
		end
	end

	// ====================================================================
	// Clock output: phase accumulator, so edges carry one-cycle jitter
	assign ph_sum = ph_r + PH_STEP;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_r <= '0;
			clk_r <= 1'b0;
		end else if (!usb_suspend) begin
			if (ph_sum >= PH_MOD) begin
				ph_r <= ph_sum - PH_MOD;
				clk_r <= !clk_r;
			end else begin
				ph_r <= ph_sum;
			end
		end
	end

	// ====================================================================
	// Activity one-shots: index 0 transmit, 1 receive
	assign trig = {rx_byte_done, tx_start_r};

	generate
		for (genvar c = 0; c < 2; c++) begin : g_shot
			uap_oneshot #(.CYCLES(LED_STRETCH)) u_shot (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.trig(trig[c]),
				.active_r(act[c])
			);
		end
	endgenerate

	// ====================================================================
	// Pin function multiplexer
	generate
		for (genvar p = 0; p < PINS; p++) begin : g_pin
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					out_r[p] <= 1'b0;
					oe_r[p] <= 1'b0;
				end else begin
					out_r[p] <= 1'b0;
					oe_r[p] <= 1'b1;
					case (sel_r[p])
						uap_pkg::UAP_FN_LINE_EN: out_r[p] <= strobe_r;
						uap_pkg::UAP_FN_PWR_EN: out_r[p] <= usb_suspend;
						uap_pkg::UAP_FN_SLEEP: out_r[p] <= !usb_suspend;
						uap_pkg::UAP_FN_TX_LED: oe_r[p] <= act[0];
						uap_pkg::UAP_FN_RX_LED: oe_r[p] <= act[1];
						uap_pkg::UAP_FN_TXRX_LED: oe_r[p] <= act[0] || act[1];
						uap_pkg::UAP_FN_CLKOUT: out_r[p] <= clk_r;
						default: oe_r[p] <= 1'b0;
					endcase
				end
			end

			chk_pwr_suspend: assert property (@(posedge core_clk) disable iff (!rst_n)
				sel_r[p] == uap_pkg::UAP_FN_PWR_EN && usb_suspend |=> out_r[p] && oe_r[p])
				else $error("power-enable low in suspend");

			chk_sleep_level: assert property (@(posedge core_clk) disable iff (!rst_n)
				sel_r[p] == uap_pkg::UAP_FN_SLEEP |=> out_r[p] == !$past(usb_suspend))
				else $error("sleep indicator wrong");

			chk_led_float: assert property (@(posedge core_clk) disable iff (!rst_n)
				sel_r[p] == uap_pkg::UAP_FN_TXRX_LED |=> oe_r[p] == $past(act[0] || act[1])
				&& !out_r[p]) else $error("combined LED wrong");
		end
	endgenerate

	// ====================================================================
	// Outputs
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign remote_wakeup = wake_r;
	assign tx_start = tx_start_r;
	assign baud_div = baud_eff_r;
	assign rxd_sync = rxd_s_r[1];
	assign cts_ok = cts_ok_r;
	assign txd_pin = txd_r;
	assign rts_n_pin = rts_n_r;
	assign aux_out = out_r;
	assign aux_oe = oe_r;

	// ====================================================================
	// Checks
	logic [15:0] hold_cnt_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt_r <= '0;
		end else begin
			hold_cnt_r <= strobe_r ? hold_cnt_r + 16'h0001 : 16'h0000;
		end
	end

	sequence s_lead_done;
		$past(state_r) == uap_pkg::UAP_ST_LEAD && tx_start_r;
	endsequence

	chk_lead_time: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_lead_done |-> hold_cnt_r == lead_len_r + 16'h0001)
		else $error("strobe lead not one bit");

	chk_strobe_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_r == uap_pkg::UAP_ST_SEND && tx_stop_bit && !go_ok |=> !strobe_r ##1 !strobe_r)
		else $error("strobe not released at stop bit");

	chk_strobe_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_r == uap_pkg::UAP_ST_IDLE && !go_ok |=> !strobe_r)
		else $error("strobe on while idle");

	chk_clk_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
		usb_suspend |=> $stable(clk_r)) else $error("clock runs in suspend");

	chk_wake_ring: assert property (@(posedge core_clk) disable iff (!rst_n)
		usb_suspend [*4] ##0 $fell(ri_s_r[2]) |-> remote_wakeup)
		else $error("no wakeup on ring");

	chk_baud_floor: assert property (@(posedge core_clk) disable iff (!rst_n)
		baud_div >= MIN_BIT) else $error("bit rate above limit");

	chk_pulldown_susp: assert property (@(posedge core_clk) disable iff (!rst_n)
		usb_suspend && pd_r |=> !txd_pin && !rts_n_pin)
		else $error("serial lines not pulled low");

	chk_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
		(avs_read || avs_write) && wait_r |=> !avs_waitrequest)
		else $error("bus answer late");

endmodule

/* sim/test_uart_aux_pin_functions.sv */
/*
 * Self-checking bench for the auxiliary pin block with a line partner model.
 * Assumes a 40 MHz core clock and a one-cycle Avalon-MM answer from the block.
 */
module test_uart_aux_pin_functions;
	timeunit 1ns;
	timeprecision 100ps;

	// ====================================================================
	// Signals
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic usb_suspend = 1'b0;
	logic remote_wakeup;
	logic tx_pending = 1'b0;
	logic tx_stop_bit = 1'b0;
	logic tx_serial = 1'b1;
	logic rx_byte_done = 1'b0;
	logic rx_room = 1'b1;
	logic tx_start, rxd_sync, cts_ok, txd_pin, rxd_pin, rts_n_pin, cts_n_pin, ri_n_pin;
	logic [15:0] baud_div;
	logic [3:0] aux_out, aux_oe;
	logic cts_block = 1'b0;
	logic ring_req = 1'b0;
	int failures = 0;
	int cmp_count = 0;

	always #12.5 core_clk = ~core_clk;

	uap_top #(.LED_STRETCH(20), .PINS(4)) u_uap_top (.core_clk(core_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.usb_suspend(usb_suspend), .remote_wakeup(remote_wakeup), .tx_pending(tx_pending),
		.tx_stop_bit(tx_stop_bit), .tx_serial(tx_serial), .rx_byte_done(rx_byte_done),
		.rx_room(rx_room), .tx_start(tx_start), .baud_div(baud_div), .rxd_sync(rxd_sync),
		.cts_ok(cts_ok), .txd_pin(txd_pin), .rxd_pin(rxd_pin), .rts_n_pin(rts_n_pin),
		.cts_n_pin(cts_n_pin), .ri_n_pin(ri_n_pin), .aux_out(aux_out), .aux_oe(aux_oe));

	uap_line_partner u_uap_line_partner (.core_clk(core_clk), .txd_pin(txd_pin),
		.rts_n_pin(rts_n_pin), .cts_block(cts_block), .ring_req(ring_req),
		.rxd_pin(rxd_pin), .cts_n_pin(cts_n_pin), .ri_n_pin(ri_n_pin));

	// ====================================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One access; waits for the answer, only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		check(n, 2);
	endtask

	task automatic toggles(input int cyc, output int c);
		logic prev;
		c = 0;
		prev = aux_out[1];
		repeat (cyc) begin
			@(posedge core_clk);
			if (aux_out[1] !== prev) c++;
			prev = aux_out[1];
		end
	endtask

	task automatic summarize;
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ====================================================================
	// Scenarios
	task automatic t_defaults;
		logic [31:0] q;
		repeat (2) @(posedge core_clk);
		#1 check(aux_oe, 4'hc);
		check(aux_out[3:2], 2'b00);
		bus(1'b0, 4'h0, 32'h0, q);
		check(q, 32'h1043);
		bus(1'b0, 4'h8, 32'h0, q);
		check(q, 32'h15b);
		bus(1'b0, 4'h2, 32'h0, q);
		check(q, 32'h0);
	endtask

	task automatic t_handshake;
		@(posedge core_clk);
		rx_room <= 1'b0;
		tx_serial <= 1'b0;
		repeat (5) @(posedge core_clk);
		#1 check(rts_n_pin, 1'b1);
		check({txd_pin, rxd_sync}, 2'b00);
		@(posedge core_clk);
		rx_room <= 1'b1;
		tx_serial <= 1'b1;
		cts_block <= 1'b1;
		repeat (5) @(posedge core_clk);
		#1 check({rts_n_pin, cts_ok, rxd_sync}, 3'b001);
		@(posedge core_clk);
		cts_block <= 1'b0;
		repeat (5) @(posedge core_clk);
		#1 check(cts_ok, 1'b1);
	endtask

	task automatic t_strobe;
		logic [31:0] q;
		int n;
		bus(1'b1, 4'h8, 32'h5, q);
		repeat (3) @(posedge core_clk);
		check(baud_div, 32'he);
		bus(1'b1, 4'h8, 32'h14, q);
		cts_block <= 1'b1;
		// The blocked handshake must pass the synchroniser before the request
		repeat (5) @(posedge core_clk);
		tx_pending <= 1'b1;
		repeat (30) @(posedge core_clk);
		check({aux_out[2], tx_start}, 2'b00);
		cts_block <= 1'b0;
		n = 0;
		while (aux_out[2] !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (tx_start !== 1'b1 && n < 100);
		check(n, 20);
		// Second character: stop bit with more to send keeps the strobe up
		tx_stop_bit <= 1'b1;
		@(posedge core_clk);
		tx_stop_bit <= 1'b0;
		tx_pending <= 1'b0;
		#1 check({tx_start, aux_out[2]}, 2'b11);
		check({aux_oe[0], aux_out[0]}, 2'b10);
		@(posedge core_clk);
		tx_stop_bit <= 1'b1;
		@(posedge core_clk);
		tx_stop_bit <= 1'b0;
		#1 check({aux_oe[2], aux_out[2]}, 2'b11);
		@(posedge core_clk);
		#1 check({aux_oe[2], aux_out[2]}, 2'b10);
	endtask

	task automatic t_leds;
		logic [31:0] q;
		// Let the transmit one-shot of the strobe scenario run out first
		repeat (25) @(posedge core_clk);
		bus(1'b1, 4'h0, 32'h1543, q);
		rx_byte_done <= 1'b1;
		@(posedge core_clk);
		rx_byte_done <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1 check({aux_oe[2:0], aux_out[2:1]}, 5'b11000);
		repeat (10) @(posedge core_clk);
		rx_byte_done <= 1'b1;
		@(posedge core_clk);
		rx_byte_done <= 1'b0;
		repeat (12) @(posedge core_clk);
		#1 check(aux_oe[2:1], 2'b11);
		repeat (30) @(posedge core_clk);
		#1 check(aux_oe[2:0], 3'b000);
	endtask

	task automatic t_suspend;
		logic [31:0] q;
		int c;
		int n;
		bus(1'b1, 4'h0, 32'h1062, q);
		toggles(200, c);
		check(c >= 119 && c <= 121, 1'b1);
		// A ring while awake must give no wakeup pulse in any cycle
		ring_req <= 1'b1;
		n = 0;
		repeat (10) begin
			@(posedge core_clk);
			if (remote_wakeup !== 1'b0) n++;
		end
		check(n, 0);
		ring_req <= 1'b0;
		usb_suspend <= 1'b1;
		bus(1'b1, 4'h4, 32'h1, q);
		repeat (4) @(posedge core_clk);
		#1 check({aux_out[3], aux_out[0], txd_pin, rts_n_pin}, 4'b1000);
		toggles(50, c);
		check(c, 0);
		bus(1'b0, 4'hc, 32'h0, q);
		check(q[0], 1'b1);
		ring_req <= 1'b1;
		n = 0;
		while (remote_wakeup !== 1'b1 && n < 10) begin
			@(posedge core_clk);
			n++;
		end
		check(n < 10, 1'b1);
		ring_req <= 1'b0;
		usb_suspend <= 1'b0;
		bus(1'b1, 4'h4, 32'h0, q);
		repeat (4) @(posedge core_clk);
		#1 check({aux_out[3], aux_out[0]}, 2'b01);
	endtask

	// ====================================================================
	// Sequence and watchdog
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		t_defaults();
		t_handshake();
		t_strobe();
		t_leds();
		t_suspend();
		summarize();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		summarize();
	end
endmodule

/* sim/uap_line_partner.sv */
/*
 * Far-side model of the serial line: a transceiver or a small controller UART.
 * Assumes the bench steers flow control and the ring line through plain inputs.
 */
module uap_line_partner (
	// Clock
	input wire logic core_clk,
	// Lines from the block
	input wire logic txd_pin,
	input wire logic rts_n_pin,
	// Bench controls
	input wire logic cts_block,
	input wire logic ring_req,
	// Lines to the block
	output logic rxd_pin,
	output logic cts_n_pin,
	output logic ri_n_pin
);
	timeunit 1ns;
	timeprecision 100ps;

	// ====================================================================
	// Line behaviour
	logic rxd_q = 1'b1;
	logic cts_n_q = 1'b0;
	logic ri_n_q = 1'b1;

	// Multi-drop line: what the block sends also comes back on receive
	always @(posedge core_clk) begin
		rxd_q <= txd_pin;
		cts_n_q <= cts_block;
		ri_n_q <= !ring_req;
	end

	assign rxd_pin = rxd_q;
	assign cts_n_pin = cts_n_q;
	assign ri_n_pin = ri_n_q;
endmodule
